// *** src/clock_divider_standby_wake.sv ***
`timescale 1ns/1ps
module clock_divider_standby_wake #(
  parameter int WAKE_TIMEOUT = clkctl_pkg::WAKE_TIMEOUT_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [clkctl_pkg::DIV_W-1:0] osc_divisor_field,
  input wire logic host_clk,
  input wire logic host_sel_n,
  input wire logic host_data,
  input wire logic bus_activity,
  input wire logic int_enable,
  input wire logic supply_switched,
  input wire logic int_ack,
  output logic logic_clk_en,
  output logic osc_run,
  output logic device_active,
  output logic supply_enable_out,
  output logic supply_enable_oe_n,
  output logic int_out,
  output logic int_oe_n,
  output logic rx_capture_en,
  output logic fifo_flush,
  output logic standby_cmd_seen,
  output logic status_read_seen
);
  import clkctl_pkg::*;

  typedef struct packed {
    power_state_e state;
    logic host_clk_q;
    logic [7:0] shift;
    logic [2:0] bit_cnt;
    logic [TIMER_W-1:0] timer;
    logic irq;
    logic rx_en;
    logic flush;
    logic osc_on;
    logic cmd_standby;
    logic cmd_status;
    logic [DIV_W-1:0] div_sel;
  } ctl_state_s;

  ctl_state_s s_r;
  ctl_state_s s_nxt;
  logic [7:0] byte_in;
  logic byte_done;
  logic host_rise;

  logic_clk_divider u_div (
    .clk(clk),
    .reset_n(reset_n),
    .run(s_r.osc_on),
    .div_sel(s_r.div_sel),
    .tick(logic_clk_en)
  );

  // Host side only advances on its own clock edges while selected
  assign host_rise = host_clk && !s_r.host_clk_q && !host_sel_n;
  assign byte_in = {s_r.shift[6:0], host_data};
  assign byte_done = host_rise && (s_r.bit_cnt == BIT_LAST);

  always_comb begin
    s_nxt = s_r;
    s_nxt.host_clk_q = host_clk;
    s_nxt.flush = 1'b0;
    s_nxt.rx_en = 1'b0;
    s_nxt.cmd_standby = 1'b0;
    s_nxt.cmd_status = 1'b0;
    // Divisor only updates while awake, so a stopped clock keeps its setting
    if (s_r.state != ST_STANDBY) begin
      s_nxt.div_sel = osc_divisor_field;
    end
    if (host_sel_n) begin
      // Deselect drops any partial byte; clock may freeze here
      s_nxt.bit_cnt = '0;
    end else if (host_rise) begin
      s_nxt.shift = byte_in;
      s_nxt.bit_cnt = s_r.bit_cnt + 3'h1;
    end
    if (byte_done) begin
      s_nxt.cmd_standby = (byte_in == CMD_STANDBY);
      s_nxt.cmd_status = (byte_in == CMD_STATUS_READ);
    end
    if (int_ack) begin
      s_nxt.irq = 1'b0;
    end
    case (s_r.state)
      ST_ACTIVE: begin
        if (byte_done && byte_in == CMD_STANDBY) begin
          s_nxt.state = ST_STANDBY;
          s_nxt.osc_on = 1'b0;
          s_nxt.irq = 1'b0;
        end
      end
      ST_STANDBY: begin
        if (byte_done && byte_in == CMD_STATUS_READ) begin
          s_nxt.state = ST_ACTIVE;
          s_nxt.osc_on = 1'b1;
          s_nxt.irq = int_enable && !supply_switched;
        end else if (bus_activity) begin
          s_nxt.state = ST_WAKE_PEND;
          s_nxt.osc_on = 1'b1;
          // Receiver armed at once so the waking frame is kept
          s_nxt.rx_en = 1'b1;
          s_nxt.timer = '0;
          s_nxt.irq = int_enable && !supply_switched;
        end
      end
      ST_WAKE_PEND: begin
        s_nxt.timer = s_r.timer + 24'h1;
        if (byte_done && byte_in == CMD_STANDBY) begin
          s_nxt.state = ST_STANDBY;
          s_nxt.osc_on = 1'b0;
          s_nxt.irq = 1'b0;
        end else if (int_ack || (byte_done && byte_in != CMD_STANDBY)) begin
          s_nxt.state = ST_ACTIVE;
        end else if (s_r.timer >= TIMER_W'(WAKE_TIMEOUT - 1)) begin
          s_nxt.state = ST_STANDBY;
          s_nxt.osc_on = 1'b0;
          s_nxt.irq = 1'b0;
        end
      end
      default: begin
        s_nxt.state = ST_ACTIVE;
        s_nxt.osc_on = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      // Power-up lands awake; flush held through reset
      s_r <= '0;
      s_r.state <= ST_ACTIVE;
      s_r.osc_on <= 1'b1;
      s_r.flush <= 1'b1;
      s_r.div_sel <= DIV_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign osc_run = s_r.osc_on;
  assign device_active = s_r.osc_on;
  assign supply_enable_out = s_r.osc_on;
  assign supply_enable_oe_n = !s_r.osc_on;
  // Open drain: drives low only while requesting
  assign int_out = 1'b0;
  assign int_oe_n = !s_r.irq;
  assign rx_capture_en = s_r.rx_en;
  assign fifo_flush = s_r.flush;
  assign standby_cmd_seen = s_r.cmd_standby;
  assign status_read_seen = s_r.cmd_status;
endmodule : clock_divider_standby_wake

// *** src/clkctl_pkg.sv ***
package clkctl_pkg;
  localparam int CLK_MHZ = 25;
  // Wake-up service window before falling back to standby
  localparam int WAKE_TIMEOUT_US = 10000;
  localparam int WAKE_TIMEOUT_CYC = WAKE_TIMEOUT_US * CLK_MHZ;
  localparam int TIMER_W = 24;
  localparam int DIV_W = 2;
  // Divisor field encoding: value plus one is the division factor
  localparam logic [1:0] DIV_BY_1 = 2'h0;
  localparam logic [1:0] DIV_BY_4 = 2'h3;
  localparam logic [1:0] DIV_RESET = DIV_BY_1;
  // Host command bytes, arbitrary values
  localparam logic [7:0] CMD_STANDBY = 8'hA5;
  localparam logic [7:0] CMD_STATUS_READ = 8'h5A;
  localparam logic [2:0] BIT_LAST = 3'h7;
  typedef enum logic [1:0] {
    ST_ACTIVE,
    ST_STANDBY,
    ST_WAKE_PEND
  } power_state_e;
endpackage : clkctl_pkg

// *** src/logic_clk_divider.sv ***
`timescale 1ns/1ps
module logic_clk_divider (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic run,
  input wire logic [clkctl_pkg::DIV_W-1:0] div_sel,
  output logic tick
);
  import clkctl_pkg::*;

  typedef struct packed {
    logic [DIV_W-1:0] count;
    logic tick;
  } div_state_s;

  div_state_s s_r;
  div_state_s s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (!run) begin
      // Stopped oscillator: restart phase cleanly on wake
      s_nxt.count = '0;
    end else if (s_r.count >= div_sel) begin
      s_nxt.count = '0;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.count = s_r.count + 2'h1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick = s_r.tick;
endmodule : logic_clk_divider

// *** sim/clkctl_chk.sv ***
`timescale 1ns/1ps
module clkctl_chk (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [1:0] osc_divisor_field,
  input wire logic bus_activity,
  input wire logic int_enable,
  input wire logic supply_switched,
  input wire logic logic_clk_en,
  input wire logic osc_run,
  input wire logic int_oe_n,
  input wire logic rx_capture_en,
  input wire logic fifo_flush,
  input wire logic standby_cmd_seen,
  input wire logic status_read_seen
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_wake;
    !osc_run && bus_activity;
  endsequence
  a_bus_wake: assert property (s_wake |=> osc_run)
    else $error("no bus wake");
  a_wake_irq: assert property (s_wake ##0 (int_enable && !supply_switched)
    |=> !int_oe_n) else $error("no wake irq");
  a_irq_cause: assert property ($fell(int_oe_n)
    |-> $past(int_enable) && !$past(supply_switched)) else $error("bad irq");
  a_rx_wake: assert property (rx_capture_en |-> $rose(osc_run))
    else $error("bad capture");
  a_div_four: assert property (logic_clk_en && osc_divisor_field == 2'h3
    |=> (!logic_clk_en || osc_divisor_field != 2'h3) [*3]) else $error("tick");
  a_standby_quiet: assert property (!osc_run && !$past(osc_run)
    |-> !logic_clk_en) else $error("tick in standby");
  a_cmd_sleep: assert property (standby_cmd_seen |-> !osc_run)
    else $error("no standby");
  a_flush_reset: assert property (fifo_flush |-> !$past(reset_n))
    else $error("late flush");
  a_status_wake: assert property (status_read_seen |-> osc_run)
    else $error("status read left asleep");
endmodule : clkctl_chk
bind clock_divider_standby_wake clkctl_chk u_chk (.*);

// *** sim/host_model.sv ***
`timescale 1ns/1ps
module host_model (
  input wire logic clk,
  output logic host_clk,
  output logic host_sel_n,
  output logic host_data
);
  initial begin
    host_clk = 1'h0;
    host_sel_n = 1'h1;
    host_data = 1'h0;
  end
  // Clock stands still outside frames; data not held after deselect
  task send(input logic [7:0] b, input int n);
    @(posedge clk);
    #1 host_sel_n = 1'h0;
    for (int i = 7; i > 7 - n; i--) begin
      host_data = b[i];
      repeat (2) @(posedge clk);
      #1 host_clk = 1'h1;
      repeat (2) @(posedge clk);
      #1 host_clk = 1'h0;
    end
    host_sel_n = 1'h1;
    host_data = ~host_data;
  endtask : send
endmodule : host_model

// *** sim/test_clock_divider_standby_wake.sv ***
`timescale 1ns/1ps
module test_clock_divider_standby_wake;
  import clkctl_pkg::*;
  logic clk = 0, reset_n = 0, bus_activity = 0, int_enable = 0, int_ack = 0;
  logic supply_switched = 0, host_clk, host_sel_n, host_data;
  logic [DIV_W-1:0] osc_divisor_field = DIV_RESET;
  logic logic_clk_en, osc_run, device_active, supply_enable_out, int_out;
  logic supply_enable_oe_n, int_oe_n, rx_capture_en, fifo_flush;
  logic standby_cmd_seen, status_read_seen;
  int error_cnt = 0, comparisons = 0, n;
  always #20 clk = ~clk;
  host_model u_host (.*);
  clock_divider_standby_wake #(.WAKE_TIMEOUT(20)) u_dut (.*);
  task chk(input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch at %0t exp %h got %h", $time, e, g);
    end
  endtask : chk
  task step(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask : step
  task wake;
    bus_activity = 1'h1;
    step(1);
    bus_activity = 1'h0;
  endtask : wake
  task conclude;
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude
  initial begin
    #100us;
    error_cnt++;
    conclude();
  end
  initial begin
    step(4);
    chk(8'h3, {fifo_flush, int_oe_n});
    reset_n = 1'h1;
    step(1);
    chk(8'h0, fifo_flush);
    chk(8'h3, {device_active, supply_enable_out});
    $display("reset done");
    for (int d = 0; d < 4; d++) begin
      osc_divisor_field = 2'(d);
      step(8);
      n = 0;
      repeat (12) begin
        n += int'(logic_clk_en === 1'b1);
        step(1);
      end
      chk(8'(12 / (d + 1)), 8'(n));
    end
    $display("divider done");
    u_host.send(8'h3C, 8);
    u_host.send(CMD_STANDBY, 4);
    step(2);
    chk(8'h1, osc_run);
    u_host.send(CMD_STANDBY, 8);
    step(2);
    chk(8'h2, {osc_run, supply_enable_oe_n, logic_clk_en});
    chk(8'h0, {device_active, supply_enable_out, int_out});
    int_enable = 1'h1;
    u_host.send(CMD_STATUS_READ, 8);
    step(2);
    chk(8'h2, {osc_run, int_oe_n});
    int_ack = 1'h1;
    step(1);
    int_ack = 1'h0;
    chk(8'h1, int_oe_n);
    u_host.send(CMD_STANDBY, 8);
    wake();
    chk(8'h6, {osc_run, rx_capture_en, int_oe_n});
    n = 0;
    while (osc_run === 1'b1 && n < 40) begin
      step(1);
      n++;
    end
    chk(8'h14, 8'(n));
    if (n == 40)
      conclude();
    chk(8'h1, int_oe_n);
    supply_switched = 1'h1;
    wake();
    chk(8'h3, {osc_run, int_oe_n});
    $display("wake done");
    conclude();
  end
endmodule : test_clock_divider_standby_wake
